// ==== verilog/pfd_pkg.sv ====
// Shared constants and types of the packet filter and framing engine
package pfd_pkg;

	// ********************************
	// Sizes and codes
	// ********************************
	localparam int          FIFO_DEPTH = 64;
	localparam int          SYNC_MAX   = 4;
	localparam logic [15:0] CCITT_SEED = 16'h1D0F;
	localparam logic [15:0] CCITT_POLY = 16'h1021;
	localparam logic [15:0] IBM_SEED   = 16'hFFFF;
	localparam logic [15:0] IBM_POLY   = 16'h8005;
	localparam logic [8:0]  WHITE_SEED = 9'h1FF;
	localparam logic [1:0]  FILT_OWN   = 2'h1;
	localparam logic [1:0]  FILT_GROUP = 2'h2;
	localparam logic [1:0]  DC_MANCH   = 2'h1;
	localparam logic [1:0]  DC_WHITE   = 2'h2;
	// Length limit that lets every length byte through
	localparam logic [10:0] LEN_OFF    = 11'h7FF;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [4:0] {
		PFD_IDLE = 5'h01,
		PFD_SYNC = 5'h02,
		PFD_PAY  = 5'h04,
		PFD_CRC  = 5'h08,
		PFD_DONE = 5'h10
	} pfd_state_e;

	typedef struct packed {
		logic [2:0]                  sync_len;
		logic [SYNC_MAX-1:0][7:0]    sync_pattern_bytes;
		logic [1:0]                  id_filter_select;
		logic [7:0]                  own_station_id;
		logic [7:0]                  group_station_id;
		logic [10:0]                 max_length_setting;
		logic                        var_length;
		logic                        checksum_enable;
		logic                        keep_on_check_fail;
		logic                        checksum_type_select;
		logic [1:0]                  balance_coding_select;
		logic                        repeat_frame_enable;
		logic [6:0]                  fifo_thresh;
	} pfd_cfg_s;

	typedef struct packed {
		logic queue_drained_flag;
		logic queue_full_flag;
		logic queue_threshold_flag;
		logic queue_overflow_flag;
		logic match_detect_flag;
		logic check_passed_flag;
		logic frame_available_flag;
		logic frame_sent;
	} pfd_flags_s;

endpackage : pfd_pkg

// ==== verilog/pfd_crc_step.sv ====
// One-bit step of the two selectable 16-bit checksums
`timescale 1ns/1ns
`default_nettype none

module pfd_crc_step (
	// Running value and input bit
	input  wire logic [15:0] crc_in,
	input  wire logic        data_bit,
	input  wire logic        ibm,
	// Updated value
	output logic      [15:0] crc_out
);

	logic fb;

	always_comb
	begin
		fb      = crc_in[15] ^ data_bit;
		crc_out = {crc_in[14:0], 1'b0};
		if (fb)
		begin
			crc_out = crc_out ^ (ibm ? pfd_pkg::IBM_POLY : pfd_pkg::CCITT_POLY);
		end
	end

endmodule : pfd_crc_step

`default_nettype wire

// ==== verilog/pfd_packet_engine.sv ====
// Packet filter, checksum, balance coding and repeat-frame engine with payload queue
`timescale 1ns/1ns
`default_nettype none

module pfd_packet_engine #(
	parameter int DEPTH = pfd_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               srst,
	// Configuration and radio mode
	input  wire pfd_pkg::pfd_cfg_s  cfg,
	input  wire logic               rx_mode,
	input  wire logic               tx_mode,
	// Host side of the queue
	input  wire logic               fifo_push,
	input  wire logic [7:0]         fifo_push_data,
	input  wire logic               fifo_pop,
	output logic      [7:0]         fifo_pop_data,
	input  wire logic               overflow_clear,
	// Status
	output pfd_pkg::pfd_flags_s     flags,
	// Demodulator chips
	input  wire logic               rx_chip_valid,
	input  wire logic               rx_chip,
	// Modulator chips
	input  wire logic               tx_chip_req,
	output logic                    tx_chip
);

	localparam int PW = $clog2(DEPTH) + 1;

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		pfd_pkg::pfd_state_e      st;
		logic [DEPTH-1:0][7:0]    mem;
		logic [PW-1:0]            wr;
		logic [PW-1:0]            rd;
		logic [PW-1:0]            pkt_start;
		logic [PW-1:0]            snap;
		logic [31:0]              shr;
		logic [7:0]               sh;
		logic [2:0]               bitcnt;
		logic [2:0]               idx;
		logic [10:0]              remain;
		logic                     ph;
		logic                     held;
		logic [8:0]               lfsr;
		logic [15:0]              crc;
		logic                     tx_on;
		logic                     tx_chip;
		logic [7:0]               rd_data;
		logic                     match;
		logic                     passed;
		logic                     avail;
		logic                     ovf;
		logic                     sent;
	} pfd_st_s;

	pfd_st_s r;
	pfd_st_s n;

	// ********************************
	// Helpers
	// ********************************
	function automatic logic sync_hit(input logic [31:0] shv,
		input logic [3:0][7:0] pat, input logic [2:0] len);
		logic ok;
		ok = (len != 3'h0);
		for (int i = 0; i < 4; i++)
		begin
			if (i < int'(len) && shv[8*(int'(len)-1-i) +: 8] != pat[i])
			begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : sync_hit

	function automatic logic [8:0] lfsr_step(input logic [8:0] l);
		return {l[0] ^ l[5], l[8:1]};
	endfunction : lfsr_step

	function automatic logic [15:0] crc_fin(input logic [15:0] c, input logic ibm);
		return ibm ? c : ~c;
	endfunction : crc_fin

	logic [PW-1:0] cnt;
	logic          full;
	logic          manch;
	logic          wht;
	logic          rx_dbit;
	logic          crc_bit;
	logic [15:0]   crc_nx;
	logic [15:0]   crc_seed;
	logic          hit;
	logic          addr_bad;
	logic          len_bad;
	logic          crc_fail;
	logic          tx_exit;
	logic          tx_byte_end;
	logic          coded;
	logic          mact;
	logic [7:0]    b;
	logic [15:0]   crc_nx_fin;
	logic [15:0]   crc_r_fin;

	assign cnt      = r.wr - r.rd;
	assign full     = (cnt == PW'(DEPTH));
	assign manch    = (cfg.balance_coding_select == pfd_pkg::DC_MANCH);
	assign wht      = (cfg.balance_coding_select == pfd_pkg::DC_WHITE);
	// Manchester takes the first chip of each pair as the bit
	assign rx_dbit  = (manch ? r.held : rx_chip) ^ (wht & r.lfsr[0]);
	assign crc_bit  = r.tx_on ? r.sh[7] : rx_dbit;
	assign crc_seed = cfg.checksum_type_select ? pfd_pkg::IBM_SEED : pfd_pkg::CCITT_SEED;
	// Finished checksum, once with the current bit folded in and once as held
	assign crc_nx_fin = crc_fin(crc_nx, cfg.checksum_type_select);
	assign crc_r_fin  = crc_fin(r.crc, cfg.checksum_type_select);

	pfd_crc_step u_crc (
		.crc_in   (r.crc),
		.data_bit (crc_bit),
		.ibm      (cfg.checksum_type_select),
		.crc_out  (crc_nx)
	);

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		n           = r;
		hit         = 1'b0;
		addr_bad    = 1'b0;
		len_bad     = 1'b0;
		crc_fail    = 1'b0;
		tx_exit     = 1'b0;
		tx_byte_end = 1'b0;
		coded       = 1'b0;
		mact        = 1'b0;
		b           = 8'h00;
		n.sent      = 1'b0;
		// Clearing overflow also empties the queue, any new event below wins
		if (overflow_clear)
		begin
			n.ovf = 1'b0;
			n.rd  = r.wr;
		end
		// Host pops are held off while transmit owns the read side
		if (fifo_pop && cnt != '0 && !r.tx_on)
		begin
			n.rd_data = r.mem[r.rd[PW-2:0]];
			n.rd      = r.rd + 1'b1;
			if (cnt == PW'(1))
			begin
				n.avail = 1'b0;
			end
		end
		if (fifo_push && !rx_mode)
		begin
			if (full)
			begin
				n.ovf = 1'b1;
			end
			else
			begin
				n.mem[r.wr[PW-2:0]] = fifo_push_data;
				n.wr                = r.wr + 1'b1;
			end
		end
		if (tx_mode)
		begin
			if (!r.tx_on)
			begin
				n.tx_on = 1'b1;
				n.snap  = r.rd;
			end
			if (r.st == pfd_pkg::PFD_IDLE && cnt != '0)
			begin
				n.st     = pfd_pkg::PFD_SYNC;
				n.sh     = cfg.sync_pattern_bytes[0];
				n.idx    = 3'h0;
				n.bitcnt = 3'h0;
				n.ph     = 1'b0;
			end
			else if (tx_chip_req && r.st != pfd_pkg::PFD_IDLE && r.st != pfd_pkg::PFD_DONE)
			begin
				mact      = manch && r.st != pfd_pkg::PFD_SYNC;
				coded     = r.sh[7] ^ (wht && r.st != pfd_pkg::PFD_SYNC && r.lfsr[0]);
				n.tx_chip = (mact && r.ph) ? ~coded : coded;
				if (mact && !r.ph)
				begin
					n.ph = 1'b1;
				end
				else
				begin
					n.ph     = 1'b0;
					n.sh     = {r.sh[6:0], 1'b0};
					n.bitcnt = r.bitcnt + 3'h1;
					if (r.st == pfd_pkg::PFD_PAY)
					begin
						n.crc = crc_nx;
					end
					if (r.st != pfd_pkg::PFD_SYNC && wht)
					begin
						n.lfsr = lfsr_step(r.lfsr);
					end
					tx_byte_end = (r.bitcnt == 3'h7);
				end
				if (tx_byte_end)
				begin
					unique case (r.st)
						pfd_pkg::PFD_SYNC:
						begin
							if (r.idx + 3'h1 < cfg.sync_len)
							begin
								n.idx = r.idx + 3'h1;
								n.sh  = cfg.sync_pattern_bytes[n.idx[1:0]];
							end
							else
							begin
								// Queue bytes go out untouched, address included
								b      = r.mem[r.rd[PW-2:0]];
								n.sh   = b;
								n.rd   = r.rd + 1'b1;
								n.st   = pfd_pkg::PFD_PAY;
								n.crc  = crc_seed;
								n.lfsr = pfd_pkg::WHITE_SEED;
								n.remain = cfg.var_length ? {3'h0, b} + 11'h1
									: cfg.max_length_setting;
							end
						end
						pfd_pkg::PFD_PAY:
						begin
							if (r.remain == 11'h1)
							begin
								if (cfg.checksum_enable)
								begin
									n.st  = pfd_pkg::PFD_CRC;
									n.idx = 3'h0;
									n.sh  = crc_nx_fin[15:8];
								end
								else
								begin
									n.st   = pfd_pkg::PFD_DONE;
									n.sent = 1'b1;
								end
							end
							else
							begin
								n.remain = r.remain - 11'h1;
								// An underrun sends zeros rather than stale data
								if (cnt != '0)
								begin
									n.sh = r.mem[r.rd[PW-2:0]];
									n.rd = r.rd + 1'b1;
								end
							end
						end
						pfd_pkg::PFD_CRC:
						begin
							if (r.idx == 3'h0)
							begin
								n.idx = 3'h1;
								n.sh  = crc_r_fin[7:0];
							end
							else
							begin
								n.st   = pfd_pkg::PFD_DONE;
								n.sent = 1'b1;
							end
						end
						default:
						begin
							n.st = pfd_pkg::PFD_IDLE;
						end
					endcase
				end
			end
		end
		else if (r.tx_on)
		begin
			tx_exit = 1'b1;
			n.tx_on = 1'b0;
			n.st    = pfd_pkg::PFD_IDLE;
			if (cfg.repeat_frame_enable)
			begin
				n.rd = r.snap;
			end
		end
		else if (!rx_mode)
		begin
			n.st    = pfd_pkg::PFD_IDLE;
			n.match = 1'b0;
		end
		else if (rx_chip_valid)
		begin
			if (r.st == pfd_pkg::PFD_IDLE)
			begin
				n.shr = {r.shr[30:0], rx_chip};
				// Nothing is written or flagged until the pattern matches
				hit   = sync_hit(n.shr, cfg.sync_pattern_bytes, cfg.sync_len);
				if (hit)
				begin
					n.st        = pfd_pkg::PFD_PAY;
					n.match     = 1'b1;
					n.passed    = 1'b0;
					n.lfsr      = pfd_pkg::WHITE_SEED;
					n.crc       = crc_seed;
					n.bitcnt    = 3'h0;
					n.idx       = 3'h0;
					n.ph        = 1'b0;
					n.pkt_start = r.wr;
					n.remain    = cfg.max_length_setting;
				end
			end
			else if (manch && !r.ph)
			begin
				n.held = rx_chip;
				n.ph   = 1'b1;
			end
			else
			begin
				n.ph     = 1'b0;
				n.sh     = {r.sh[6:0], rx_dbit};
				n.shr    = {r.shr[30:0], rx_dbit};
				n.bitcnt = r.bitcnt + 3'h1;
				if (wht)
				begin
					n.lfsr = lfsr_step(r.lfsr);
				end
				if (r.st == pfd_pkg::PFD_PAY)
				begin
					n.crc = crc_nx;
				end
				if (r.bitcnt == 3'h7)
				begin
					b = n.sh;
					if (r.st == pfd_pkg::PFD_PAY)
					begin
						// Length and address bytes are stored like payload
						if (full)
						begin
							n.ovf = 1'b1;
						end
						else
						begin
							n.mem[r.wr[PW-2:0]] = b;
							n.wr                = r.wr + 1'b1;
						end
						if (r.idx != 3'h7)
						begin
							n.idx = r.idx + 3'h1;
						end
						if (cfg.var_length && r.idx == 3'h0)
						begin
							len_bad  = ({3'h0, b} >= cfg.max_length_setting);
							n.remain = {3'h0, b};
						end
						else
						begin
							n.remain = r.remain - 11'h1;
							if (cfg.id_filter_select != 2'h0
								&& r.idx == (cfg.var_length ? 3'h1 : 3'h0))
							begin
								addr_bad = (b != cfg.own_station_id)
									&& !(cfg.id_filter_select == pfd_pkg::FILT_GROUP
									&& b == cfg.group_station_id);
							end
						end
						if (len_bad || addr_bad)
						begin
							n.wr    = r.pkt_start;
							n.st    = pfd_pkg::PFD_IDLE;
							n.match = 1'b0;
						end
						else if (n.remain == 11'h0)
						begin
							if (cfg.checksum_enable)
							begin
								n.st  = pfd_pkg::PFD_CRC;
								n.idx = 3'h0;
							end
							else
							begin
								n.st    = pfd_pkg::PFD_IDLE;
								n.match = 1'b0;
								n.avail = 1'b1;
							end
						end
					end
					else if (r.idx == 3'h0)
					begin
						n.idx = 3'h1;
					end
					else
					begin
						// Checksum bytes are compared only, never stored
						n.st    = pfd_pkg::PFD_IDLE;
						n.match = 1'b0;
						if (n.shr[15:0] == crc_r_fin)
						begin
							n.passed = 1'b1;
							n.avail  = 1'b1;
						end
						else
						begin
							crc_fail = 1'b1;
							if (cfg.keep_on_check_fail)
							begin
								n.avail = 1'b1;
							end
							else
							begin
								n.rd = n.wr;
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			r    <= '0;
			r.st <= pfd_pkg::PFD_IDLE;
		end
		else
		begin
			r <= n;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign fifo_pop_data              = r.rd_data;
	assign tx_chip                    = r.tx_chip;
	assign flags.queue_drained_flag   = (cnt == '0);
	assign flags.queue_full_flag      = full;
	assign flags.queue_threshold_flag = (cnt > cfg.fifo_thresh);
	assign flags.queue_overflow_flag  = r.ovf;
	assign flags.match_detect_flag    = r.match;
	assign flags.check_passed_flag    = r.passed;
	assign flags.frame_available_flag = r.avail;
	assign flags.frame_sent           = r.sent;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sequence s_pay_last;
		tx_byte_end && r.st == pfd_pkg::PFD_PAY && r.remain == 11'h1;
	endsequence
	sequence s_manch_second;
		tx_mode && tx_chip_req && manch && r.ph
			&& (r.st == pfd_pkg::PFD_PAY || r.st == pfd_pkg::PFD_CRC);
	endsequence

	property p_no_silent_match;
		$rose(r.match) |-> $past(hit);
	endproperty
	property p_sync_starts;
		hit |=> r.st == pfd_pkg::PFD_PAY && r.match;
	endproperty
	property p_addr_drop;
		addr_bad |=> r.st == pfd_pkg::PFD_IDLE && !r.match && r.wr == $past(r.pkt_start);
	endproperty
	property p_len_drop;
		len_bad |=> r.st == pfd_pkg::PFD_IDLE && r.wr == $past(r.pkt_start);
	endproperty
	property p_crc_flush;
		crc_fail && !cfg.keep_on_check_fail |=> cnt == '0;
	endproperty
	property p_crc_keep;
		crc_fail && cfg.keep_on_check_fail && !fifo_pop && !overflow_clear
			|=> r.avail && !r.passed && cnt == $past(cnt);
	endproperty
	property p_crc_strip;
		r.st == pfd_pkg::PFD_CRC && !r.tx_on && rx_mode |=> r.wr == $past(r.wr);
	endproperty
	property p_seeds;
		hit |=> r.crc == $past(crc_seed) && r.lfsr == pfd_pkg::WHITE_SEED;
	endproperty
	property p_manch_pair;
		s_manch_second |=> r.tx_chip != $past(r.tx_chip);
	endproperty
	property p_crc_append;
		s_pay_last ##0 cfg.checksum_enable |=> r.st == pfd_pkg::PFD_CRC ##1 r.idx == 3'h0;
	endproperty
	property p_beacon;
		tx_exit && cfg.repeat_frame_enable |=> r.rd == $past(r.snap) && !r.tx_on;
	endproperty
	property p_bound;
		cnt <= PW'(DEPTH);
	endproperty

	a_no_silent_match: assert property (p_no_silent_match) else $error("match without sync");
	a_sync_starts: assert property (p_sync_starts) else $error("sync did not start payload");
	a_addr_drop: assert property (p_addr_drop) else $error("bad address not dropped");
	a_len_drop: assert property (p_len_drop) else $error("bad length not dropped");
	a_crc_flush: assert property (p_crc_flush) else $error("queue not flushed");
	a_crc_keep: assert property (p_crc_keep) else $error("failed frame not kept");
	a_crc_strip: assert property (p_crc_strip) else $error("checksum byte stored");
	a_seeds: assert property (p_seeds) else $error("wrong seed at packet start");
	a_manch_pair: assert property (p_manch_pair) else $error("chip pair not complementary");
	a_crc_append: assert property (p_crc_append) else $error("checksum not appended");
	a_beacon: assert property (p_beacon) else $error("queue not restored");
	a_bound: assert property (p_bound) else $error("queue above depth");

endmodule : pfd_packet_engine

`default_nettype wire

// ==== bench/pfd_remote_node.sv ====
// Far radio node: feeds received chips and pulls transmitted chips
`timescale 1ns/1ns
`default_nettype none

module pfd_remote_node (
	// Clock
	input  wire logic core_clk,
	// Chips toward the engine
	output var logic  rx_chip_valid,
	output var logic  rx_chip,
	// Chips from the engine
	output var logic  tx_chip_req,
	input  wire logic tx_chip
);
	initial
	begin
		rx_chip_valid = 1'b0;
		rx_chip       = 1'b0;
		tx_chip_req   = 1'b0;
	end

	// Random gaps between chips; a gap shows the inverse of the chip before it
	task automatic send(input logic c[$]);
		foreach (c[i])
		begin
			@(posedge core_clk);
			rx_chip_valid <= 1'b1;
			rx_chip       <= c[i];
			repeat ($urandom_range(0, 2))
			begin
				@(posedge core_clk);
				rx_chip_valid <= 1'b0;
				rx_chip       <= ~c[i];
			end
		end
		@(posedge core_clk);
		rx_chip_valid <= 1'b0;
		rx_chip       <= ~rx_chip;
	endtask : send

	task automatic grab(input int n, output logic q[$]);
		q = {};
		repeat (n)
		begin
			repeat ($urandom_range(0, 2)) @(posedge core_clk);
			@(posedge core_clk);
			tx_chip_req <= 1'b1;
			@(posedge core_clk);
			tx_chip_req <= 1'b0;
			@(posedge core_clk);
			q.push_back(tx_chip);
		end
	endtask : grab
endmodule : pfd_remote_node

`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the packet engine against a queue model
`timescale 1ns/1ns
`default_nettype none

module tb;
	typedef logic pfd_chq_t[$];
	logic                core_clk = 1'b0;
	logic                srst = 1'b1;
	pfd_pkg::pfd_cfg_s   cfg = '0;
	logic                rx_mode = 1'b0;
	logic                tx_mode = 1'b0;
	logic                fifo_push = 1'b0;
	logic [7:0]          fifo_push_data = 8'h00;
	logic                fifo_pop = 1'b0;
	logic [7:0]          fifo_pop_data;
	logic                overflow_clear = 1'b0;
	pfd_pkg::pfd_flags_s flags;
	logic                rx_chip_valid;
	logic                rx_chip;
	logic                tx_chip_req;
	logic                tx_chip;
	int                  n_match_cyc = 0;
	int                  n_sent_cyc = 0;
	int                  n_mismatch = 0;
	int                  num_checks = 0;

	always #4 core_clk = ~core_clk;

	pfd_packet_engine pfd_packet_engine_i (.core_clk, .srst, .cfg, .rx_mode, .tx_mode,
		.fifo_push, .fifo_push_data, .fifo_pop, .fifo_pop_data, .overflow_clear, .flags,
		.rx_chip_valid, .rx_chip, .tx_chip_req, .tx_chip);
	pfd_remote_node pfd_remote_node_i (.core_clk, .rx_chip_valid, .rx_chip, .tx_chip_req,
		.tx_chip);

	always @(posedge core_clk)
	begin
		if (flags.match_detect_flag === 1'b1)
			n_match_cyc <= n_match_cyc + 1;
		if (flags.frame_sent === 1'b1)
			n_sent_cyc <= n_sent_cyc + 1;
	end

	// ****
	// Checking and model
	// ****
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// Chips on air: NRZ sync, then coded payload and checksum
	function automatic pfd_chq_t code_frame(input logic [7:0] b[$], input bit bad);
		logic [15:0] crc;
		logic [8:0]  wl;
		logic        x;
		pfd_chq_t    q;
		crc = cfg.checksum_type_select ? 16'hFFFF : 16'h1D0F;
		wl = 9'h1FF;
		for (int i = 0; i < cfg.sync_len; i++)
			for (int k = 7; k >= 0; k--)
				q.push_back(cfg.sync_pattern_bytes[i][k]);
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i][k]) ?
					(cfg.checksum_type_select ? 16'h8005 : 16'h1021) : 16'h0000);
		if (!cfg.checksum_type_select)
			crc = ~crc;
		crc[0] ^= bad;
		if (cfg.checksum_enable)
		begin
			b.push_back(crc[15:8]);
			b.push_back(crc[7:0]);
		end
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
			begin
				x = b[i][k];
				if (cfg.balance_coding_select == 2'h2)
				begin
					x ^= wl[0];
					wl = {wl[0] ^ wl[5], wl[8:1]};
				end
				q.push_back(x);
				if (cfg.balance_coding_select == 2'h1)
					q.push_back(~x);
			end
		return q;
	endfunction : code_frame

	// ****
	// Host queue access
	// ****
	task automatic fill(input logic [7:0] b[$]);
		foreach (b[i])
		begin
			@(posedge core_clk);
			fifo_push      <= 1'b1;
			fifo_push_data <= b[i];
		end
		@(posedge core_clk);
		fifo_push <= 1'b0;
	endtask : fill

	task automatic drain(input logic [7:0] exp[$]);
		foreach (exp[i])
		begin
			@(posedge core_clk);
			fifo_pop <= 1'b1;
			@(posedge core_clk);
			fifo_pop <= 1'b0;
			@(posedge core_clk);
			check("pop", exp[i], fifo_pop_data);
		end
		check("empty", 1, flags.queue_drained_flag);
	endtask : drain

	// Random settings; the host never mixes both balance codings or zero sync bytes
	function automatic pfd_pkg::pfd_cfg_s rand_cfg;
		pfd_pkg::pfd_cfg_s c;
		c = '0;
		c.sync_len = 3'($urandom_range(2, 4));
		foreach (c.sync_pattern_bytes[i])
			c.sync_pattern_bytes[i] = 8'($urandom_range(1, 255));
		c.id_filter_select = 2'($urandom_range(0, 2));
		c.own_station_id = 8'($urandom);
		c.group_station_id = 8'($urandom);
		c.var_length = 1'($urandom);
		c.checksum_enable = 1'($urandom);
		c.keep_on_check_fail = 1'($urandom);
		c.checksum_type_select = 1'($urandom);
		c.balance_coding_select = 2'($urandom_range(0, 2));
		return c;
	endfunction : rand_cfg

	// ****
	// Scenarios
	// ****
	task automatic rx_case;
		pfd_pkg::pfd_cfg_s c;
		logic [7:0]        p[$];
		int                n;
		int                a;
		int                m0;
		bit                bad;
		bit                acc;
		pfd_chq_t          ch;
		c = rand_cfg();
		n = $urandom_range(1, 7);
		c.max_length_setting = c.var_length ? 11'($urandom_range(2, 6)) : 11'(n);
		if (c.var_length && $urandom_range(0, 3) == 0)
			c.max_length_setting = pfd_pkg::LEN_OFF;
		if (c.var_length)
			p.push_back(8'(n));
		repeat (n) p.push_back(8'($urandom));
		a = c.var_length;
		if ($urandom_range(0, 2) == 0)
			p[a] = c.own_station_id;
		else if ($urandom_range(0, 1) == 0)
			p[a] = c.group_station_id;
		bad = $urandom_range(0, 3) == 0;
		acc = $urandom_range(0, 5) != 0;
		@(posedge core_clk);
		cfg        <= c;
		rx_mode    <= 1'b1;
		m0 = n_match_cyc;
		@(posedge core_clk);
		ch = code_frame(p, bad);
		ch[0] = ch[0] ^ !acc;
		pfd_remote_node_i.send(ch);
		repeat (3) @(posedge core_clk);
		check("match", acc, n_match_cyc != m0);
		acc &= !(c.var_length && n >= c.max_length_setting);
		acc &= c.id_filter_select == 2'h0 || p[a] == c.own_station_id
			|| (c.id_filter_select == 2'h2 && p[a] == c.group_station_id);
		if (acc && c.checksum_enable)
			check("crc", !bad, flags.check_passed_flag);
		acc &= !(c.checksum_enable && bad && !c.keep_on_check_fail);
		check("ready", acc, flags.frame_available_flag);
		if (!acc)
			p = {};
		@(posedge core_clk);
		rx_mode <= 1'b0;
		drain(p);
	endtask : rx_case

	task automatic tx_case;
		pfd_pkg::pfd_cfg_s c;
		logic [7:0]        p[$];
		int                n;
		pfd_chq_t          got;
		pfd_chq_t          exp;
		int                s0;
		c = rand_cfg();
		n = $urandom_range(1, 6);
		c.max_length_setting = 11'(n);
		c.repeat_frame_enable = !c.var_length && 1'($urandom);
		if (c.var_length)
			p.push_back(8'(n));
		repeat (n) p.push_back(8'($urandom));
		@(posedge core_clk);
		cfg <= c;
		fill(p);
		s0 = n_sent_cyc;
		tx_mode   <= 1'b1;
		repeat (2) @(posedge core_clk);
		exp = code_frame(p, 1'b0);
		pfd_remote_node_i.grab(exp.size(), got);
		foreach (exp[i])
			check("chip", exp[i], got[i]);
		repeat (2) @(posedge core_clk);
		check("sent", 1, 16'(n_sent_cyc - s0));
		check("empty", 1, flags.queue_drained_flag);
		tx_mode <= 1'b0;
		repeat (2) @(posedge core_clk);
		if (c.repeat_frame_enable)
		begin
			check("empty", 0, flags.queue_drained_flag);
			drain(p);
			c.repeat_frame_enable = 1'b0;
			cfg            <= c;
			overflow_clear <= 1'b1;
			@(posedge core_clk);
			overflow_clear <= 1'b0;
		end
	endtask : tx_case

	task automatic fifo_case;
		logic [7:0] p[$];
		repeat (65) p.push_back(8'($urandom));
		fill(p);
		@(posedge core_clk);
		check("full", 1, flags.queue_full_flag);
		check("ovf", 1, flags.queue_overflow_flag);
		check("thr", 1, flags.queue_threshold_flag);
		void'(p.pop_back());
		drain(p);
		overflow_clear <= 1'b1;
		@(posedge core_clk);
		overflow_clear <= 1'b0;
		@(posedge core_clk);
		check("ovf", 0, flags.queue_overflow_flag);
	endtask : fifo_case

	initial
	begin
		void'($urandom(52354));
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		check("empty", 1, flags.queue_drained_flag);
		fifo_case;
		repeat (40) rx_case;
		repeat (24) tx_case;
		give_verdict;
	end

	// Runs should finish well before 90k cycles; reaching 90k means a hang
	initial
	begin
		repeat (90000) @(posedge core_clk);
		n_mismatch++;
		give_verdict;
	end
endmodule : tb

`default_nettype wire
